/* File: core/bfs_pkg.sv */
// constants for the boot flash serial master
package bfs_pkg;
    // =====================================================================
    // link rate limits
    // =====================================================================
    localparam int BFS_CLK_MHZ = 100;
    localparam real BFS_SCK_MIN_MHZ = 1.4;
    localparam real BFS_SCK_MAX_MHZ = 36.0;
    // half-period in mclk cycles: least rounds up, longest rounds down
    localparam int BFS_HALF_MIN = 2;
    localparam int BFS_HALF_MAX = 35;
    localparam int BFS_HALF_MIN_CALC = int'($ceil(BFS_CLK_MHZ / (2.0 * BFS_SCK_MAX_MHZ)));
    localparam int BFS_HALF_MAX_CALC = int'($floor(BFS_CLK_MHZ / (2.0 * BFS_SCK_MIN_MHZ)));
    localparam int BFS_DIV_W = 6;
    localparam logic [5:0] BFS_DIV_RESET = 6'h02;
    // =====================================================================
    // addressing
    // =====================================================================
    localparam int BFS_ADDR_W = 24;
    localparam int BFS_LEN_W = 24;
    localparam int BFS_CNT_W = 3;
    localparam logic [2:0] BFS_BIT_LAST = 3'h7;
    localparam logic [1:0] BFS_ADDR_BYTES = 2'h3;
    localparam logic [BFS_ADDR_W-1:0] BFS_ADDR_LIMIT = 24'hffffff;
    // =====================================================================
    // sequencer states
    // =====================================================================
    typedef enum logic [2:0] {
        BFS_IDLE,
        BFS_INSTR,
        BFS_ADDR,
        BFS_DATA,
        BFS_END
    } bfs_state_t;
endpackage

/* File: core/bfs_clkdiv.sv */
// serial clock divider producing edge strobes
`timescale 1ns/10ps
module bfs_clkdiv #(
    parameter int DIV_W = bfs_pkg::BFS_DIV_W
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire logic [DIV_W-1:0] half_in,
    // edges
    output logic sck_out,
    output logic rise_out,
    output logic fall_out
);
    import bfs_pkg::*;

    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic sck_r, sck_nxt;
    logic rise_nxt;
    logic fall_nxt;

    // =====================================================================
    // divider
    // =====================================================================
    always_comb begin
        cnt_nxt = cnt_r;
        sck_nxt = sck_r;
        rise_nxt = 1'b0;
        fall_nxt = 1'b0;
        if (!run_in) begin
            cnt_nxt = '0;
            sck_nxt = 1'b0;
        end else if (cnt_r + DIV_W'(1) >= half_in) begin
            cnt_nxt = '0;
            sck_nxt = !sck_r;
            rise_nxt = !sck_r;
            fall_nxt = sck_r;
        end else begin
            cnt_nxt = cnt_r + DIV_W'(1);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            sck_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sck_r <= sck_nxt;
        end
    end

    assign sck_out = sck_r;
    // strobes lead the clock edge by one cycle
    assign rise_out = rise_nxt;
    assign fall_out = fall_nxt;
endmodule

/* File: core/bfs_master.sv */
// boot flash serial master: read sequencer and pins
// Functional notes
// - serial clock divided, 1.4 to 36 MHz
// - 24-bit address covers 1 to 128 Mb
// - data out and select change on falling
// - incoming data sampled on falling edge
`timescale 1ns/10ps
module bfs_master
    import bfs_pkg::*;
#(
    parameter int DIV_W = bfs_pkg::BFS_DIV_W
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // rate control
    input wire logic [DIV_W-1:0] half_in,
    // request
    input wire logic start_in,
    input wire logic [7:0] instr_in,
    input wire logic addr_en_in,
    input wire logic [bfs_pkg::BFS_ADDR_W-1:0] addr_in,
    input wire logic [bfs_pkg::BFS_LEN_W-1:0] len_in,
    // answer
    output logic busy_out,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    output logic done_out,
    // flash pins
    output logic flash_clk_out,
    output logic flash_select_n_out,
    output logic flash_dout_out,
    input wire logic flash_din_in
);
    import bfs_pkg::*;

    // elaboration checks
    if (DIV_W < 6) begin : g_div_chk
        $error("divider too narrow");
    end
    if (BFS_HALF_MIN != BFS_HALF_MIN_CALC ||
        BFS_HALF_MAX != BFS_HALF_MAX_CALC) begin : g_rate_chk
        $error("rate limits inconsistent");
    end

    // =====================================================================
    // input sync and rate clamp
    // =====================================================================
    logic din_s1_r, din_s2_r;
    logic [DIV_W-1:0] half_eff;
    logic sck, fall, run_r, run_nxt;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            din_s1_r <= flash_din_in;
            din_s2_r <= din_s1_r;
        end
    end

    always_comb begin
        half_eff = half_in;
        if (half_in < DIV_W'(BFS_HALF_MIN)) half_eff = DIV_W'(BFS_HALF_MIN);
        if (half_in > DIV_W'(BFS_HALF_MAX)) half_eff = DIV_W'(BFS_HALF_MAX);
    end

    bfs_clkdiv #(.DIV_W(DIV_W)) u_div (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .run_in(run_r),
        .half_in(half_eff),
        .sck_out(sck),
        .rise_out(),
        .fall_out(fall)
    );

    // =====================================================================
    // sequencer
    // =====================================================================
    bfs_state_t st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [1:0] abyte_r, abyte_nxt;
    logic [BFS_ADDR_W-1:0] addr_r, addr_nxt;
    logic [BFS_LEN_W-1:0] len_r, len_nxt;
    logic cs_n_r, cs_n_nxt, dout_r, dout_nxt;
    logic rv_r, rv_nxt, done_r, done_nxt;
    logic busy_r, busy_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        rx_nxt = rx_r;
        bit_nxt = bit_r;
        abyte_nxt = abyte_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        cs_n_nxt = cs_n_r;
        dout_nxt = dout_r;
        run_nxt = run_r;
        rv_nxt = 1'b0;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        unique case (st_r)
            BFS_IDLE: begin
                if (start_in) begin
                    sh_nxt = {instr_in[6:0], 1'b0};
                    dout_nxt = instr_in[7];
                    cs_n_nxt = 1'b0;
                    addr_nxt = addr_in & BFS_ADDR_LIMIT;
                    len_nxt = len_in;
                    bit_nxt = '0;
                    run_nxt = 1'b1;
                    st_nxt = BFS_INSTR;
                end
            end
            BFS_INSTR, BFS_ADDR, BFS_DATA: begin
                if (fall) begin
                    rx_nxt = {rx_r[6:0], din_s2_r};
                    bit_nxt = bit_r + 3'h1;
                    dout_nxt = sh_r[7];
                    sh_nxt = {sh_r[6:0], 1'b0};
                    if (bit_r == BFS_BIT_LAST) begin
                        if (st_r == BFS_DATA) begin
                            rdata_nxt = {rx_r[6:0], din_s2_r};
                            rv_nxt = 1'b1;
                            len_nxt = len_r - BFS_LEN_W'(1);
                        end
                        if (st_r == BFS_INSTR && addr_en_in) begin
                            st_nxt = BFS_ADDR;
                            abyte_nxt = 2'h1;
                            dout_nxt = addr_r[23];
                            sh_nxt = {addr_r[22:16], 1'b0};
                        end else if (st_r == BFS_ADDR && abyte_r != BFS_ADDR_BYTES) begin
                            abyte_nxt = abyte_r + 2'h1;
                            dout_nxt = (abyte_r == 2'h1) ? addr_r[15] : addr_r[7];
                            sh_nxt = (abyte_r == 2'h1) ? {addr_r[14:8], 1'b0}
                                : {addr_r[6:0], 1'b0};
                        end else if (len_r == '0 ||
                            (st_r == BFS_DATA && len_r == BFS_LEN_W'(1))) begin
                            st_nxt = BFS_END;
                            run_nxt = 1'b0;
                            cs_n_nxt = 1'b1;
                        end else begin
                            st_nxt = BFS_DATA;
                            dout_nxt = 1'b0;
                            sh_nxt = '0;
                        end
                    end
                end
            end
            BFS_END: begin
                done_nxt = 1'b1;
                st_nxt = BFS_IDLE;
            end
            default: st_nxt = BFS_IDLE;
        endcase
        busy_nxt = (st_nxt != BFS_IDLE);
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_r <= BFS_IDLE;
            sh_r <= '0;
            rx_r <= '0;
            bit_r <= '0;
            abyte_r <= '0;
            addr_r <= '0;
            len_r <= '0;
            cs_n_r <= 1'b1;
            dout_r <= 1'b0;
            run_r <= 1'b0;
            rv_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            rx_r <= rx_nxt;
            bit_r <= bit_nxt;
            abyte_r <= abyte_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            cs_n_r <= cs_n_nxt;
            dout_r <= dout_nxt;
            run_r <= run_nxt;
            rv_r <= rv_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign busy_out = busy_r;
    assign rdata_out = rdata_r;
    assign rvalid_out = rv_r;
    assign done_out = done_r;
    assign flash_clk_out = sck;
    assign flash_select_n_out = cs_n_r;
    assign flash_dout_out = dout_r;

    // =====================================================================
    // checks
    // =====================================================================
    dout_on_fall_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $changed(flash_dout_out) && !$past(cs_n_r) |-> $past(fall) || $past(st_r) == BFS_IDLE)
        else $error("data changed off falling edge");
    sel_low_clk_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(flash_clk_out) |-> !flash_select_n_out)
        else $error("clock edge outside select");
    sel_rise_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(flash_select_n_out) |-> !flash_clk_out ##1 !flash_clk_out)
        else $error("select rose with clock high");
    rate_bound_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(flash_clk_out) |-> flash_clk_out[*2])
        else $error("clock high too short");
    rate_slow_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(flash_clk_out) |-> ##[1:36] !flash_clk_out)
        else $error("clock high too long");
    rx_capture_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        fall && st_r != BFS_IDLE |=> rx_r[0] == $past(din_s2_r))
        else $error("capture not on falling edge");
    addr_mask_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        st_r == BFS_IDLE && start_in |=> addr_r == $past(addr_in))
        else $error("address not taken");
    done_pulse_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        done_out |-> flash_select_n_out ##1 !done_out)
        else $error("done without select release");
endmodule

/* File: tb/bfs_flash_model.sv */
// behavioural serial flash partner for the boot flash master
`timescale 1ns/10ps
module bfs_flash_model (
    // serial pins
    input wire logic clk_in,
    input wire logic sel_n_in,
    input wire logic di_in,
    output logic do_out,
    // answer speed and log
    input wire logic slow_in,
    output logic [7:0] instr_out,
    output logic [23:0] addr_out
);
    int nbit = 0;
    int hlen = 64;
    int dbit = 0;
    logic [31:0] hdr = 32'h0;
    logic [23:0] a = 24'h0;
    logic [7:0] cur;
    logic drv = 1'b0;
    logic bitv = 1'b0;
    // released line shows the inverse of the last bit
    assign do_out = drv ? bitv : ~bitv;
    always @(negedge sel_n_in) begin
        nbit = 0;
        dbit = 0;
        hlen = 64;
    end
    always @(posedge sel_n_in) drv = 1'b0;
    // capture on rising, instruction then address, msb first
    always @(posedge clk_in) if (!sel_n_in) begin
        hdr = {hdr[30:0], di_in};
        nbit++;
        if (nbit == 8) begin
            instr_out = hdr[7:0];
            hlen = (hdr[7:0] == 8'h03) ? 32 : 8;
        end
        if (nbit == hlen) begin
            a = (hlen == 32) ? hdr[23:0] : 24'h0;
            addr_out = a;
        end
    end
    // launch after falling, msb first
    always @(negedge clk_in) if (!sel_n_in && nbit >= hlen) begin
        #(slow_in ? 7 : 1);
        if (!sel_n_in) begin
            cur = a[7:0] ^ a[23:16] ^ 8'ha5;
            bitv = cur[7-dbit];
            drv = 1'b1;
            dbit++;
            if (dbit == 8) begin
                dbit = 0;
                a++;
            end
        end
    end
endmodule

/* File: tb/tb.sv */
// self-checking bench for the boot flash serial master
`timescale 1ns/10ps
module tb;
    import bfs_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [5:0] half = 6'h02;
    logic start = 1'b0;
    logic [7:0] instr = 8'h00;
    logic aen = 1'b0;
    logic [23:0] addr = 24'h0;
    logic [23:0] len = 24'h0;
    logic slow = 1'b0;
    logic busy, rvalid, done, fclk, fsel_n, fdo, fdi, p_clk, p_do, p_sel;
    logic [7:0] rdata;
    logic [7:0] m_instr;
    logic [23:0] m_addr;
    logic [31:0] rnd = 32'h91137962;
    int fails = 0;
    int check_count = 0;
    time last_rise = 0;
    initial forever #5 mclk_in = ~mclk_in;
    bfs_master i_bfs_master (.mclk_in(mclk_in), .rst_in(rst_in), .half_in(half),
        .start_in(start), .instr_in(instr), .addr_en_in(aen), .addr_in(addr), .len_in(len),
        .busy_out(busy), .rdata_out(rdata), .rvalid_out(rvalid), .done_out(done),
        .flash_clk_out(fclk), .flash_select_n_out(fsel_n), .flash_dout_out(fdo),
        .flash_din_in(fdi));
    bfs_flash_model u_flash (.clk_in(fclk), .sel_n_in(fsel_n), .di_in(fdo), .do_out(fdi),
        .slow_in(slow), .instr_out(m_instr), .addr_out(m_addr));
    // =====================================================================
    // checking helpers
    // =====================================================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // pin timing watch
    always @(posedge mclk_in) begin
        #1;
        if (!rst_in && !p_sel && !fsel_n && fdo !== p_do)
            chk("dout_on_fall", 32'({p_clk, fclk}), 32'h2);
        if (!p_sel && fsel_n === 1'b1) chk("sel_clk_low", 32'(fclk), 32'h0);
        if (!p_clk && fclk === 1'b1) begin
            if (last_rise != 0)
                chk("sck_period", 32'(($time - last_rise) inside {[28:704]}), 32'h1);
            last_rise = $time;
        end
        if (fsel_n) last_rise = 0;
        p_clk = fclk;
        p_do = fdo;
        p_sel = fsel_n;
    end
    // =====================================================================
    // one read transaction against the reference byte queue
    // =====================================================================
    task automatic run(input logic [7:0] ins, input logic ae, input logic [23:0] ad,
                       input int n, input logic [5:0] hf, input logic sl);
        int t;
        int k;
        int exp_q[$];
        for (k = 0; k < n; k++) begin
            t = ((ae ? ad : 0) + k) % 16777216;
            exp_q.push_back((t % 256) ^ (t / 65536) ^ 165);
        end
        @(posedge mclk_in);
        instr <= ins;
        aen <= ae;
        addr <= ad;
        len <= 24'(n);
        half <= hf;
        slow <= sl;
        start <= 1'b1;
        @(posedge mclk_in);
        start <= 1'b0;
        #1;
        chk("busy_held", 32'(busy), 32'h1);
        t = 0;
        k = 0;
        while (done !== 1'b1 && t < 20000) begin
            @(posedge mclk_in);
            #1;
            t++;
            if (rvalid === 1'b1 && exp_q.size() > 0) chk("rdata", 32'(rdata), exp_q.pop_front());
            if (rvalid === 1'b1) k++;
        end
        chk("finished", 32'(t < 20000), 32'h1);
        chk("busy_clear", 32'(busy), 32'h0);
        chk("byte_count", 32'(k), 32'(n));
        chk("instr_sent", 32'(m_instr), 32'(ins));
        if (ae) chk("addr_sent", 32'(m_addr), 32'(ad));
        $display("test done: instr %h addr %h len %0d half %0d", ins, ad, n, hf);
    endtask
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        run(8'h03, 1'b1, 24'h000000, 3, 6'h02, 1'b0);
        run(8'h03, 1'b1, 24'hffffff, 2, 6'h23, 1'b1);
        run(8'h9f, 1'b0, 24'h000000, 0, 6'h00, 1'b0);
        run(8'h9f, 1'b0, 24'h000000, 2, 6'h3f, 1'b1);
        repeat (4) begin
            rnd = lfsr(rnd);
            run(rnd[0] ? 8'h03 : 8'h9f, rnd[0], rnd[31:8], 1 + rnd[3:1] % 4,
                6'(2 + rnd[13:8] % 34), rnd[4]);
        end
        summarize();
    end
    initial begin
        #600000;
        fails++;
        summarize();
    end
endmodule
